// file: hdl/io_expander.sv
// Contract
// - Forty pins, five banks, per-pin direction
// - Bank outputs change at data byte acknowledge
// - Masked pins never raise the change interrupt
// - Inverted pins read back complemented
// - Open-drain interrupt on unmasked input change
// - Output enable high tri-states outputs, keeps values
// - Reset makes all forty pins inputs
// - Reset restores every setting and bus logic
// - Three address pins form low address bits
// - First byte bit zero: one reads, zero writes
// - First write byte loads the command register
// - Works at 100 kHz and 400 kHz
// - Glitches under 50 ns are rejected
// - Low six command bits point at register
// - Auto-step low pointer bits, wrap at five
// - Command register resets to 0x80
// - Writes to input banks are not acknowledged
`timescale 1ns/1ps
`default_nettype none

module io_expander (
    input  wire logic                     clock,            // 200 MHz clock
    input  wire logic                     arst_n,           // Reset pin
    input  wire logic                     scl_in,           // Serial clock
    input  wire logic                     sda_in,           // Serial data in
    output var  logic                     sda_out,          // Data level, 0
    output var  logic                     sda_oe,           // Pull data low
    input  wire logic                     addr_select_bit0, // Address bit 0
    input  wire logic                     addr_select_bit1, // Address bit 1
    input  wire logic                     addr_select_bit2, // Address bit 2
    input  wire logic                     out_enable_n,     // Output enable
    input  wire logic [expander_pkg::IO_W-1:0] io_in,       // Pin levels
    output var  logic [expander_pkg::IO_W-1:0] io_out,      // Pin drive
    output var  logic [expander_pkg::IO_W-1:0] io_oe,       // Pin enable
    output var  logic                     int_out,          // Int level, 0
    output var  logic                     int_oe            // Pull int low
);
    import expander_pkg::*;

    serial_line_if bus ();

    serial_line_filter u_filter (
        .clock  (clock),
        .arst_n (arst_n),
        .scl_in (scl_in),
        .sda_in (sda_in),
        .bus    (bus)
    );

    // ********************************************************************
    // Helpers
    // ********************************************************************
    // Auto-step: bump low bits, skip reserved, wrap at last bank
    function automatic logic [7:0] step_ptr(input logic [7:0] cmd);
        logic [7:0] r;
        r = cmd;
        if (cmd[AUTO_STEP_BIT]) begin
            if (cmd[2:0] >= 3'(LAST_BANK)) begin
                r[2:0] = 3'h0;
            end else begin
                r[2:0] = cmd[2:0] + 3'h1;
            end
        end
        return r;
    endfunction

    // Pointer lands on a real bank of the given group
    function automatic logic ptr_hits(input logic [7:0] cmd,
                                      input logic [2:0] grp);
        return cmd[5:3] == grp && cmd[2:0] <= 3'(LAST_BANK);
    endfunction

    // ********************************************************************
    // Pin synchronisers
    // ********************************************************************
    logic [IO_W-1:0] pin_meta_r, pin_sync_r;
    logic [3:0]      ctl_meta_r, ctl_sync_r;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
            ctl_meta_r <= 4'h8;
            ctl_sync_r <= 4'h8;
        end else begin
            pin_meta_r <= io_in;
            pin_sync_r <= pin_meta_r;
            ctl_meta_r <= {out_enable_n, addr_select_bit2,
                           addr_select_bit1, addr_select_bit0};
            ctl_sync_r <= ctl_meta_r;
        end
    end

    // ********************************************************************
    // Serial slave and register banks
    // ********************************************************************
    slave_state_e state_r,  state_nxt;
    logic [3:0]   bitcnt_r, bitcnt_nxt;
    logic [7:0]   shift_r,  shift_nxt;
    logic [7:0]   cmd_r,    cmd_nxt;
    logic         sda_oe_r, sda_oe_nxt;
    logic [1:0]   init_r,   init_nxt;
    logic [7:0]   drv_r  [NUM_BANKS];
    logic [7:0]   drv_nxt[NUM_BANKS];
    logic [7:0]   inv_r  [NUM_BANKS];
    logic [7:0]   inv_nxt[NUM_BANKS];
    logic [7:0]   dir_r  [NUM_BANKS];
    logic [7:0]   dir_nxt[NUM_BANKS];
    logic [7:0]   msk_r  [NUM_BANKS];
    logic [7:0]   msk_nxt[NUM_BANKS];
    logic [7:0]   last_r [NUM_BANKS];
    logic [7:0]   last_nxt[NUM_BANKS];
    logic [7:0]   rd_byte;
    logic [2:0]   bk;

    // Byte the pointer selects for a read
    always_comb begin
        bk      = (cmd_r[2:0] <= 3'(LAST_BANK)) ? cmd_r[2:0] : 3'h0;
        rd_byte = RD_IDLE;
        if (ptr_hits(cmd_r, GRP_LEVEL)) begin
            rd_byte = pin_sync_r[bk*BANK_W +: BANK_W] ^ inv_r[bk];
        end else if (ptr_hits(cmd_r, GRP_DRIVE)) begin
            rd_byte = drv_r[bk];
        end else if (ptr_hits(cmd_r, GRP_INVERT)) begin
            rd_byte = inv_r[bk];
        end else if (ptr_hits(cmd_r, GRP_DIR)) begin
            rd_byte = dir_r[bk];
        end else if (ptr_hits(cmd_r, GRP_MASK)) begin
            rd_byte = msk_r[bk];
        end
    end

    // Next state of the slave and its registers
    always_comb begin
        state_nxt  = state_r;
        bitcnt_nxt = bitcnt_r;
        shift_nxt  = shift_r;
        cmd_nxt    = cmd_r;
        sda_oe_nxt = sda_oe_r;
        init_nxt   = init_r;
        drv_nxt    = drv_r;
        inv_nxt    = inv_r;
        dir_nxt    = dir_r;
        msk_nxt    = msk_r;
        last_nxt   = last_r;
        // Seed the reference levels once synchronisers have filled
        if (init_r != INIT_DONE) begin
            init_nxt = init_r + 2'h1;
            for (int i = 0; i < NUM_BANKS; i++) begin
                last_nxt[i] = pin_sync_r[i*BANK_W +: BANK_W];
            end
        end
        if (bus.start) begin
            state_nxt  = ST_ADDR;
            bitcnt_nxt = 4'h0;
            sda_oe_nxt = 1'b0;
        end else if (bus.stop) begin
            state_nxt  = ST_IDLE;
            sda_oe_nxt = 1'b0;
        end else if (bus.scl_rise) begin
            case (state_r)
                ST_ADDR, ST_CMD, ST_WDATA: begin
                    shift_nxt  = {shift_r[6:0], bus.sda};
                    bitcnt_nxt = bitcnt_r + 4'h1;
                end
                ST_RACK: begin
                    shift_nxt[0] = bus.sda;
                end
                default: begin
                end
            endcase
        end else if (bus.scl_fall) begin
            case (state_r)
                ST_ADDR: begin
                    if (bitcnt_r == BITS_BYTE) begin
                        bitcnt_nxt = 4'h0;
                        if (shift_r[7:1] ==
                            {ADDR_UPPER, ctl_sync_r[2:0]}) begin
                            sda_oe_nxt = 1'b1;
                            state_nxt  = ST_AACK;
                        end else begin
                            state_nxt  = ST_IDLE;
                        end
                    end
                end
                ST_AACK: begin
                    sda_oe_nxt = 1'b0;
                    if (shift_r[0] == RW_READ) begin
                        state_nxt  = ST_RDATA;
                        shift_nxt  = rd_byte;
                        sda_oe_nxt = ~rd_byte[7];
                        bitcnt_nxt = 4'h1;
                        cmd_nxt    = step_ptr(cmd_r);
                        if (ptr_hits(cmd_r, GRP_LEVEL)) begin
                            last_nxt[bk] =
                                pin_sync_r[bk*BANK_W +: BANK_W];
                        end
                    end else begin
                        state_nxt = ST_CMD;
                    end
                end
                ST_CMD: begin
                    if (bitcnt_r == BITS_BYTE) begin
                        bitcnt_nxt = 4'h0;
                        cmd_nxt    = shift_r;
                        sda_oe_nxt = 1'b1;
                        state_nxt  = ST_CACK;
                    end
                end
                ST_CACK, ST_WACK: begin
                    sda_oe_nxt = 1'b0;
                    state_nxt  = ST_WDATA;
                end
                ST_WDATA: begin
                    if (bitcnt_r == BITS_BYTE) begin
                        bitcnt_nxt = 4'h0;
                        cmd_nxt    = step_ptr(cmd_r);
                        sda_oe_nxt = 1'b1;
                        state_nxt  = ST_WACK;
                        if (ptr_hits(cmd_r, GRP_DRIVE)) begin
                            drv_nxt[bk] = shift_r;
                        end else if (ptr_hits(cmd_r, GRP_INVERT)) begin
                            inv_nxt[bk] = shift_r;
                        end else if (ptr_hits(cmd_r, GRP_DIR)) begin
                            dir_nxt[bk] = shift_r;
                        end else if (ptr_hits(cmd_r, GRP_MASK)) begin
                            msk_nxt[bk] = shift_r;
                        end else begin
                            sda_oe_nxt = 1'b0;
                            state_nxt  = ST_IDLE;
                        end
                    end
                end
                ST_RDATA: begin
                    if (bitcnt_r == BITS_BYTE) begin
                        bitcnt_nxt = 4'h0;
                        sda_oe_nxt = 1'b0;
                        state_nxt  = ST_RACK;
                    end else begin
                        shift_nxt  = {shift_r[6:0], 1'b0};
                        sda_oe_nxt = ~shift_r[6];
                        bitcnt_nxt = bitcnt_r + 4'h1;
                    end
                end
                ST_RACK: begin
                    if (shift_r[0] == 1'b0) begin
                        state_nxt  = ST_RDATA;
                        shift_nxt  = rd_byte;
                        sda_oe_nxt = ~rd_byte[7];
                        bitcnt_nxt = 4'h1;
                        cmd_nxt    = step_ptr(cmd_r);
                        if (ptr_hits(cmd_r, GRP_LEVEL)) begin
                            last_nxt[bk] =
                                pin_sync_r[bk*BANK_W +: BANK_W];
                        end
                    end else begin
                        state_nxt = ST_IDLE;
                    end
                end
                default: begin
                    state_nxt = state_r;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_r  <= ST_IDLE;
            bitcnt_r <= 4'h0;
            shift_r  <= 8'h00;
            cmd_r    <= CMD_RST;
            sda_oe_r <= 1'b0;
            init_r   <= 2'h0;
            for (int i = 0; i < NUM_BANKS; i++) begin
                drv_r[i]  <= DRV_RST;
                inv_r[i]  <= INV_RST;
                dir_r[i]  <= DIR_RST;
                msk_r[i]  <= MSK_RST;
                last_r[i] <= 8'h00;
            end
        end else begin
            state_r  <= state_nxt;
            bitcnt_r <= bitcnt_nxt;
            shift_r  <= shift_nxt;
            cmd_r    <= cmd_nxt;
            sda_oe_r <= sda_oe_nxt;
            init_r   <= init_nxt;
            drv_r    <= drv_nxt;
            inv_r    <= inv_nxt;
            dir_r    <= dir_nxt;
            msk_r    <= msk_nxt;
            last_r   <= last_nxt;
        end
    end

    // ********************************************************************
    // Pin drivers and change interrupt
    // ********************************************************************
    logic [IO_W-1:0] io_out_nxt, io_oe_nxt;
    logic            int_nxt;

    always_comb begin
        int_nxt = 1'b0;
        for (int i = 0; i < NUM_BANKS; i++) begin
            io_out_nxt[i*BANK_W +: BANK_W] = drv_r[i];
            io_oe_nxt[i*BANK_W +: BANK_W]  =
                ~dir_r[i] & {BANK_W{~ctl_sync_r[3]}};
            if (init_r == INIT_DONE &&
                |((pin_sync_r[i*BANK_W +: BANK_W] ^ last_r[i])
                  & dir_r[i] & ~msk_r[i])) begin
                int_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            io_out  <= '0;
            io_oe   <= '0;
            int_oe  <= 1'b0;
            int_out <= 1'b0;
            sda_out <= 1'b0;
            sda_oe  <= 1'b0;
        end else begin
            io_out  <= io_out_nxt;
            io_oe   <= io_oe_nxt;
            int_oe  <= int_nxt;
            int_out <= 1'b0;
            sda_out <= 1'b0;
            sda_oe  <= sda_oe_r;
        end
    end

endmodule

`default_nettype wire

// file: hdl/expander_pkg.sv
package expander_pkg;

    // ********************************************************************
    // Geometry
    // ********************************************************************
    localparam int          NUM_BANKS  = 5;
    localparam int          BANK_W     = 8;
    localparam int          IO_W       = 40;
    localparam int          LAST_BANK  = 4;

    // ********************************************************************
    // Command byte layout and pointer groups
    // ********************************************************************
    localparam logic [7:0]  CMD_RST       = 8'h80;
    localparam int          AUTO_STEP_BIT = 7;
    localparam int          PTR_W         = 6;
    localparam logic [2:0]  GRP_LEVEL     = 3'h0;
    localparam logic [2:0]  GRP_DRIVE     = 3'h1;
    localparam logic [2:0]  GRP_INVERT    = 3'h2;
    localparam logic [2:0]  GRP_DIR       = 3'h3;
    localparam logic [2:0]  GRP_MASK      = 3'h4;

    // ********************************************************************
    // Register reset values (direction 1 = input)
    // ********************************************************************
    localparam logic [7:0]  DRV_RST    = 8'h00;
    localparam logic [7:0]  INV_RST    = 8'h00;
    localparam logic [7:0]  DIR_RST    = 8'hff;
    localparam logic [7:0]  MSK_RST    = 8'h00;
    localparam logic [7:0]  RD_IDLE    = 8'hff;

    // ********************************************************************
    // Slave address: fixed upper bits (value arbitrary), direction bit
    // ********************************************************************
    localparam logic [3:0]  ADDR_UPPER = 4'h2;
    localparam logic        RW_READ    = 1'b1;
    localparam logic [3:0]  BITS_BYTE  = 4'h8;

    // ********************************************************************
    // Timing
    // ********************************************************************
    localparam int          CLK_NS     = 5;
    localparam int          FILT_NS    = 50;
    localparam int          FILT_CYC   = (FILT_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0]  FILT_LAST  = 4'(FILT_CYC - 1);
    localparam logic [1:0]  INIT_DONE  = 2'h3;

    // ********************************************************************
    // Serial slave states
    // ********************************************************************
    typedef enum logic [8:0] {
        ST_IDLE  = 9'h001,
        ST_ADDR  = 9'h002,
        ST_AACK  = 9'h004,
        ST_CMD   = 9'h008,
        ST_CACK  = 9'h010,
        ST_WDATA = 9'h020,
        ST_WACK  = 9'h040,
        ST_RDATA = 9'h080,
        ST_RACK  = 9'h100
    } slave_state_e;

endpackage

// file: hdl/serial_line_if.sv
`timescale 1ns/1ps
`default_nettype none

// Filtered serial lines and their events
interface serial_line_if;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    modport filt (output scl, sda, scl_rise, scl_fall, start, stop);
    modport core (input  scl, sda, scl_rise, scl_fall, start, stop);
endinterface

`default_nettype wire

// file: hdl/serial_line_filter.sv
`timescale 1ns/1ps
`default_nettype none

module serial_line_filter
    import expander_pkg::*;
(
    input  wire logic       clock,    // System clock
    input  wire logic       arst_n,   // Async reset, active low
    input  wire logic       scl_in,   // Serial clock pin
    input  wire logic       sda_in,   // Serial data pin
    serial_line_if.filt     bus       // Filtered levels and events
);

    logic [1:0] meta_r;
    logic [1:0] sync_r;
    logic [1:0] level_r,  level_nxt;
    logic [3:0] cnt_r [2];
    logic [3:0] cnt_nxt [2];
    logic [3:0] ev_r,     ev_nxt;

    // ********************************************************************
    // Two-flop synchronisers
    // ********************************************************************
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            meta_r <= 2'h3;
            sync_r <= 2'h3;
        end else begin
            meta_r <= {sda_in, scl_in};
            sync_r <= meta_r;
        end
    end

    // ********************************************************************
    // Accept a level only after it stays put for the filter span
    // ********************************************************************
    always_comb begin
        level_nxt = level_r;
        for (int i = 0; i < 2; i++) begin
            cnt_nxt[i] = 4'h0;
            if (sync_r[i] != level_r[i]) begin
                if (cnt_r[i] == FILT_LAST) begin
                    level_nxt[i] = sync_r[i];
                end else begin
                    cnt_nxt[i] = cnt_r[i] + 4'h1;
                end
            end
        end
        // Events: scl rise, scl fall, start, stop
        ev_nxt[0] = level_nxt[0] & ~level_r[0];
        ev_nxt[1] = ~level_nxt[0] & level_r[0];
        ev_nxt[2] = level_r[0] & level_nxt[0] & level_r[1] & ~level_nxt[1];
        ev_nxt[3] = level_r[0] & level_nxt[0] & ~level_r[1] & level_nxt[1];
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            level_r  <= 2'h3;
            cnt_r[0] <= 4'h0;
            cnt_r[1] <= 4'h0;
            ev_r     <= 4'h0;
        end else begin
            level_r  <= level_nxt;
            cnt_r    <= cnt_nxt;
            ev_r     <= ev_nxt;
        end
    end

    assign bus.scl      = level_r[0];
    assign bus.sda      = level_r[1];
    assign bus.scl_rise = ev_r[0];
    assign bus.scl_fall = ev_r[1];
    assign bus.start    = ev_r[2];
    assign bus.stop     = ev_r[3];

endmodule

`default_nettype wire

// file: verif/io_expander_checker.sv
`timescale 1ns/1ps
`default_nettype none

// *****
// Port checker
// *****
module io_expander_checker (
    input wire logic                            clock,            // Clock
    input wire logic                            arst_n,           // Reset
    input wire logic                            scl_in,           // Clock pin
    input wire logic                            sda_in,           // Data pin
    input wire logic                            sda_out,          // Data 0
    input wire logic                            sda_oe,           // Data pull
    input wire logic                            addr_select_bit0, // Addr 0
    input wire logic                            addr_select_bit1, // Addr 1
    input wire logic                            addr_select_bit2, // Addr 2
    input wire logic                            out_enable_n,     // Enable
    input wire logic [expander_pkg::IO_W-1:0]   io_in,            // Pins
    input wire logic [expander_pkg::IO_W-1:0]   io_out,           // Drive
    input wire logic [expander_pkg::IO_W-1:0]   io_oe,            // Enable
    input wire logic                            int_out,          // Int 0
    input wire logic                            int_oe            // Int pull
);
    import expander_pkg::*;
    logic [IO_W-1:0] pin_r;
    logic [3:0]      age_r;
    logic [3:0]      age_nxt;

    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);

    // Cycles since the pins last moved
    always_comb age_nxt = (io_in != pin_r) ? 4'h0 :
                          age_r + {3'h0, age_r != 4'hf};
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pin_r <= '0;
            age_r <= 4'hf;
        end else begin
            pin_r <= io_in;
            age_r <= age_nxt;
        end
    end

    chk_open_drain: assert property (!sda_out && !int_out)
        else $error("open-drain output driven high");
    chk_reset_quiet: assert property ($rose(arst_n) |->
        io_oe == '0 && io_out == '0 && !sda_oe)
        else $error("outputs not idle after reset");
    chk_seed_no_int: assert property ($rose(arst_n) |-> !int_oe [*3])
        else $error("interrupt during seeding");
    chk_oe_tristate: assert property (out_enable_n [*3] |=> io_oe == '0)
        else $error("pins driven while disabled");
    chk_out_at_ack: assert property ($changed(io_out) |->
        sda_oe || $past(sda_oe))
        else $error("drive changed outside acknowledge");
    chk_sda_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data changed while clock high");
    chk_int_cause: assert property ($rose(int_oe) |->
        age_r < 4'h8 || sda_oe)
        else $error("interrupt without cause");
    chk_oe_cause: assert property ($changed(io_oe) |-> sda_oe ||
        $past(sda_oe) || $past(out_enable_n, 3) != $past(out_enable_n, 4))
        else $error("pin enable changed without cause");

    cov_int: cover property ($rose(int_oe));
    cov_out: cover property ($changed(io_out));
    cov_ack: cover property ($rose(sda_oe));
endmodule

bind io_expander io_expander_checker io_expander_checker_i (.*);

`default_nettype wire

// file: verif/bus_master_model.sv
`timescale 1ns/1ps
`default_nettype none

// *****
// Serial bus master model
// *****
module bus_master_model (
    input  wire logic dev_pull, // Device pulls data
    output var  logic scl,      // Clock line
    output wire logic sda       // Data line, pulled up
);
    logic low_r = 1'b0;

    // Open-drain data line with pull-up
    assign sda = !(low_r || dev_pull);
    initial scl = 1'b1;

    // One bit: data set mid-low, sampled mid-high
    task automatic xbit(input logic b, output logic r);
        #40 low_r = !b;
        #40 scl = 1'b1;
        #40 r = sda;
        #40 scl = 1'b0;
    endtask
    // Start or repeated start
    task automatic start();
        low_r = 1'b0;
        #80 scl = 1'b1;
        #40 low_r = 1'b1;
        #40 scl = 1'b0;
    endtask
    task automatic stop();
        #40 low_r = 1'b1;
        #40 scl = 1'b1;
        #40 low_r = 1'b0;
        #40;
    endtask
    // Byte out, bit zero carries direction in the first byte
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) xbit(d[i], r);
        xbit(1'b1, r);
        ack = !r;
    endtask
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xbit(1'b1, r);
            d[i] = r;
        end
        xbit(last, r);
    endtask
endmodule

`default_nettype wire

// file: verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_errors++; \
    $display("CHECK FAILED %0t: got %h want %h", $time, a, e); end end

// *****
// Bench
// *****
module tb;
    import expander_pkg::*;
    logic            clock = 0, arst_n = 0, out_enable_n = 0;
    logic [2:0]      a_sel = 3'h0, tgt = 3'h0;
    logic [IO_W-1:0] ext = '0, io_out, io_oe, res_val, exp_q[$];
    logic            sda_out, sda_oe, int_out, int_oe;
    wire [IO_W-1:0]  io_in;
    wire             scl, sda;
    int              n_errors = 0, check_count = 0;
    event            res_ev;

    // Pin level: device where enabled, bench elsewhere
    assign io_in = (io_oe & io_out) | (~io_oe & ext);
    always #2.5 clock = ~clock;

    io_expander io_expander_i (.clock(clock), .arst_n(arst_n),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .addr_select_bit0(a_sel[0]), .addr_select_bit1(a_sel[1]),
        .addr_select_bit2(a_sel[2]), .out_enable_n(out_enable_n),
        .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
        .int_out(int_out), .int_oe(int_oe));
    bus_master_model bus_master_model_i (.dev_pull(sda_oe), .scl(scl),
        .sda(sda));

    // Compare each result with the oldest note
    always @(res_ev) `CHK(res_val, exp_q.pop_front())

    task automatic put(input logic [IO_W-1:0] e, input logic [IO_W-1:0] a);
        exp_q.push_back(e);
        res_val = a;
        -> res_ev;
        #1;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wr(input logic [7:0] c, input logic [IO_W-1:0] d,
                      input int n, output logic [6:0] ak);
        logic b;
        ak = '0;
        bus_master_model_i.start();
        bus_master_model_i.wbyte({ADDR_UPPER, tgt, 1'b0}, b);
        ak[0] = b;
        bus_master_model_i.wbyte(c, b);
        ak[1] = b;
        for (int i = 0; i < n; i++) begin
            bus_master_model_i.wbyte(d[8*i +: 8], b);
            ak[2+i] = b;
        end
        bus_master_model_i.stop();
    endtask
    task automatic rd(input logic wc, input logic [7:0] c, input int n,
                      output logic [IO_W-1:0] q);
        logic       b;
        logic [7:0] v;
        q = '0;
        if (wc) begin
            bus_master_model_i.start();
            bus_master_model_i.wbyte({ADDR_UPPER, tgt, 1'b0}, b);
            bus_master_model_i.wbyte(c, b);
        end
        bus_master_model_i.start();
        bus_master_model_i.wbyte({ADDR_UPPER, tgt, RW_READ}, b);
        for (int i = 0; i < n; i++) begin
            bus_master_model_i.rbyte(i == n - 1, v);
            q[8*i +: 8] = v;
        end
        bus_master_model_i.stop();
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Main sequence
    initial begin
        logic [IO_W-1:0] drv, dir, inv, pin, q;
        logic [6:0]      ak;
        void'($urandom(32'hf5348b2d));
        tick(2);
        arst_n = 1'b1;
        tick(4);
        for (int i = 0; i < 16; i++) begin
            a_sel = 3'(i / 2);
            tgt = a_sel ^ 3'((i % 2) * 5);
            tick(4);
            wr(8'h80, '0, 0, ak);
            put((i % 2) ? 40'h0 : 40'h3, 40'(ak));
        end
        $display("address done");
        a_sel = 3'($urandom);
        tgt = a_sel;
        drv = 40'({$urandom, $urandom});
        dir = 40'({$urandom, $urandom}) | 40'hff;
        tick(4);
        wr(8'h88, drv, 5, ak);
        put(40'h7f, 40'(ak));
        wr(8'h98, dir, 5, ak);
        put(40'h7f, 40'(ak));
        tick(4);
        put(drv, io_out);
        put(~dir, io_oe);
        out_enable_n = 1'b1;
        tick(5);
        put('0, io_oe);
        put(drv, io_out);
        out_enable_n = 1'b0;
        tick(5);
        put(~dir, io_oe);
        wr(8'h00, 40'h5a, 1, ak);
        put(40'h3, 40'(ak));
        $display("write done");
        inv = 40'($urandom & 32'hff);
        ext = 40'({$urandom, $urandom});
        pin = (~dir & drv) | (dir & ext);
        tick(4);
        wr(8'h12, inv, 1, ak);
        rd(1'b1, 8'h82, 5, q);
        put({pin[15:0], pin[39:24], pin[23:16] ^ inv[7:0]}, q);
        tick(20);
        put('0, 40'(int_oe));
        wr(8'ha0, 40'hff, 1, ak);
        ext[0] = ~ext[0];
        tick(20);
        put('0, 40'(int_oe));
        wr(8'ha0, 40'h0, 1, ak);
        tick(20);
        put(40'h1, 40'(int_oe));
        ext[0] = ~ext[0];
        tick(20);
        put('0, 40'(int_oe));
        $display("read and interrupt done");
        arst_n = 1'b0;
        tick(2);
        put('0, io_oe);
        put('0, io_out);
        arst_n = 1'b1;
        tick(4);
        rd(1'b0, 8'h00, 2, q);
        put({24'h0, ext[15:0]}, q);
        $display("reset done");
        print_verdict();
    end

    // Cut a hung run short
    initial begin
        #400000;
        n_errors++;
        print_verdict();
    end
endmodule

`default_nettype wire
